// ### design/adc_conversion_control.sv
// Conversion control for an 8-channel 10-bit successive approximation converter
//
// Summary of operation
// - Free run restarts conversion after each finish
// - Clearing free run stops automatic restarts
// - Done flag sets at each finish, even when a locked result is not stored
// - Request needs flag, enable and global enable
// - Vector acknowledge clears the done flag
// - Writing one clears done flag, zero keeps
// - Divider code selects two up to 128
// - Result low byte, high byte bits 1..0
// - Channel change waits for conversion end
// - Free run restart coincides with done request
// - Start bit reads one until real finish
// - Lengths 13 free run, 14 single, 25 first
// - Low read locks results until high read
// - Clearing enable aborts any running conversion
`default_nettype none
module adc_conversion_control (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [adc_ctrl_pkg::ADR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic global_irq_enable_i,
  input wire logic irq_vector_ack_i,
  output logic conv_irq_o,
  output logic irq_o,
  input wire logic [adc_ctrl_pkg::RESULT_W-1:0] core_result_i,
  output logic [adc_ctrl_pkg::CHAN_W-1:0] channel_o,
  output logic converting_o,
  output logic converter_on_o,
  output logic adc_clk_en_o
);
  import adc_ctrl_pkg::*;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic access;
  logic wr;
  logic rd;
  logic wr_lane0;
  logic [5:0] idx;
  logic [7:0] wbyte;

  assign access = cyc_i && stb_i && !ack_o;
  assign wr = access && we_i;
  assign rd = access && !we_i;
  assign wr_lane0 = wr && sel_i[0];
  assign idx = adr_i[ADR_W-1:2];
  assign wbyte = dat_i[7:0];

  function automatic logic hit(input logic [5:0] a, input logic [5:0] b);
    hit = (a == b);
  endfunction

  logic wr_ctrl;
  logic wr_chan;
  logic wr_ev;
  logic wr_mask;
  logic rd_low;
  logic rd_high;

  assign wr_ctrl = wr_lane0 && hit(idx, IDX_CTRL_STATUS);
  assign wr_chan = wr_lane0 && hit(idx, IDX_CHANNEL);
  assign wr_ev = wr_lane0 && hit(idx, IDX_IRQ_STATUS);
  assign wr_mask = wr_lane0 && hit(idx, IDX_IRQ_MASK);
  assign rd_low = rd && hit(idx, IDX_RESULT_LOW);
  assign rd_high = rd && hit(idx, IDX_RESULT_HIGH);

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  logic enable;
  logic free_run_select;
  logic conversion_done_irq_enable;
  logic [DIV_W-1:0] converter_clock_divider_select;
  logic [CHAN_W-1:0] input_channel_select;
  logic [EV_W-1:0] irq_mask;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      enable <= 1'b0;
      free_run_select <= 1'b0;
      conversion_done_irq_enable <= 1'b0;
      converter_clock_divider_select <= DIV_RESET;
    end else if (ce_i && wr_ctrl) begin
      enable <= wbyte[CS_ENABLE];
      free_run_select <= wbyte[CS_FREE_RUN];
      conversion_done_irq_enable <= wbyte[CS_IRQ_ENABLE];
      converter_clock_divider_select <= wbyte[CS_DIV_LSB +: DIV_W];
    end
  end

  // Channel is only a request; the multiplexer follows the captured copy
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      input_channel_select <= CHAN_RESET;
    end else if (ce_i && wr_chan) begin
      input_channel_select <= wbyte[CHAN_W-1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_mask <= EV_RESET;
    end else if (ce_i && wr_mask) begin
      irq_mask <= wbyte[EV_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Converter clock
  // ----------------------------------------------------------------
  logic tick;

  converter_prescaler prescaler (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .run_i(enable),
    .div_sel_i(converter_clock_divider_select),
    .tick_o(tick)
  );

  // ----------------------------------------------------------------
  // Conversion sequencer
  // ----------------------------------------------------------------
  conv_state_t state;
  logic [TICK_W-1:0] tick_cnt;
  logic [TICK_W-1:0] conv_len;
  logic need_init;
  logic [CHAN_W-1:0] active_channel;
  logic start_req;
  logic done_evt;
  logic busy;

  assign busy = (state == converting_st);
  // A start written together with the enable bit is accepted
  assign start_req = wr_ctrl && wbyte[CS_START] && wbyte[CS_ENABLE] && !busy;
  assign done_evt = busy && enable && tick && (tick_cnt == conv_len - 5'h01);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= idle_st;
      tick_cnt <= 5'h00;
      conv_len <= CLKS_SINGLE;
      active_channel <= CHAN_RESET;
    end else if (ce_i) begin
      if (!enable && !start_req) begin
        state <= idle_st;
        tick_cnt <= 5'h00;
      end else begin
        unique case (state)
          idle_st: begin
            if (start_req) begin
              state <= converting_st;
              tick_cnt <= 5'h00;
              conv_len <= need_init ? CLKS_INIT : CLKS_SINGLE;
              active_channel <= input_channel_select;
            end
          end
          converting_st: begin
            if (done_evt) begin
              tick_cnt <= 5'h00;
              if (free_run_select) begin
                conv_len <= CLKS_FREE_RUN;
                active_channel <= input_channel_select;
              end else begin
                state <= idle_st;
              end
            end else if (tick) begin
              tick_cnt <= tick_cnt + 5'h01;
            end
          end
        endcase
      end
    end
  end

  // Initialisation pass is owed after reset and after every switch-off
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      need_init <= 1'b1;
    end else if (ce_i) begin
      if (start_req) begin
        need_init <= 1'b0;
      end else if (!enable) begin
        need_init <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Result capture and ordered-read lock
  // ----------------------------------------------------------------
  logic [RESULT_W-1:0] result_meta;
  logic [RESULT_W-1:0] result_sync;
  logic [RESULT_W-1:0] conversion_result_bits;
  logic locked;

  // Core output is asynchronous to this clock, so it is double registered
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      result_meta <= RESULT_RESET;
      result_sync <= RESULT_RESET;
    end else if (ce_i) begin
      result_meta <= core_result_i;
      result_sync <= result_meta;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      conversion_result_bits <= RESULT_RESET;
    end else if (ce_i && done_evt && !locked) begin
      conversion_result_bits <= result_sync;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      locked <= 1'b0;
    end else if (ce_i) begin
      if (rd_low) begin
        locked <= 1'b1;
      end else if (rd_high) begin
        locked <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Completion flag and event status
  // ----------------------------------------------------------------
  logic conversion_done_flag;
  logic [EV_W-1:0] irq_status;
  logic [EV_W-1:0] ev_set;

  assign ev_set = {done_evt && locked, done_evt};

  // A completion in the clearing cycle wins over the clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      conversion_done_flag <= 1'b0;
    end else if (ce_i) begin
      if (done_evt) begin
        conversion_done_flag <= 1'b1;
      end else if (irq_vector_ack_i) begin
        conversion_done_flag <= 1'b0;
      end else if (wr_ctrl && wbyte[CS_DONE_FLAG]) begin
        conversion_done_flag <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_status <= EV_RESET;
    end else if (ce_i) begin
      if (wr_ev) begin
        irq_status <= (irq_status & ~wbyte[EV_W-1:0]) | ev_set;
      end else begin
        irq_status <= irq_status | ev_set;
      end
    end
  end

  assign conv_irq_o = conversion_done_flag && conversion_done_irq_enable
                      && global_irq_enable_i;
  assign irq_o = |(irq_status & irq_mask);

  // ----------------------------------------------------------------
  // Read data and acknowledge
  // ----------------------------------------------------------------
  logic [7:0] read_byte;

  always_comb begin
    read_byte = 8'h00;
    unique case (idx)
      IDX_RESULT_LOW: read_byte = conversion_result_bits[7:0];
      IDX_RESULT_HIGH: read_byte = {6'h00, conversion_result_bits[9:8]};
      IDX_CTRL_STATUS: read_byte = {enable, busy, free_run_select, conversion_done_flag,
                                    conversion_done_irq_enable,
                                    converter_clock_divider_select};
      IDX_CHANNEL: read_byte = {5'h00, input_channel_select};
      IDX_IRQ_STATUS: read_byte = {6'h00, irq_status};
      IDX_IRQ_MASK: read_byte = {6'h00, irq_mask};
      default: read_byte = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else if (ce_i) begin
      ack_o <= access;
      if (rd) begin
        dat_o <= {24'h00_0000, read_byte};
      end
    end
  end

  assign channel_o = active_channel;
  assign converting_o = busy;
  assign converter_on_o = enable;
  assign adc_clk_en_o = tick;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_free_run_restart: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
    done_evt && free_run_select |=> busy && tick_cnt == 5'h00 && conv_len == CLKS_FREE_RUN)
    else $error("free run did not restart");
  chk_single_stops: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
    done_evt && !free_run_select && !start_req |=> !busy)
    else $error("single conversion did not stop");
  chk_flag_on_done: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
    done_evt |=> conversion_done_flag)
    else $error("done flag not set");
  chk_irq_gating: assert property (@(posedge clk_i) disable iff (rst_i)
    conv_irq_o |-> conversion_done_flag && conversion_done_irq_enable)
    else $error("request without flag and enable");
  chk_vector_clear: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
    irq_vector_ack_i && !done_evt |=> !conversion_done_flag)
    else $error("vector acknowledge left flag set");
  chk_flag_write_zero: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
    conversion_done_flag && wr_ctrl && !wbyte[CS_DONE_FLAG] && !irq_vector_ack_i
    |=> conversion_done_flag) else $error("zero write cleared flag");
  chk_divide_two: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
    tick && converter_clock_divider_select <= 3'h1 && !wr_ctrl && enable |-> ##2 tick)
    else $error("divide by two rate wrong");
  chk_locked_hold: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
    done_evt && locked |=> $stable(conversion_result_bits) && irq_status[EV_LOST])
    else $error("locked result changed");
  chk_disable_abort: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
    !enable && !start_req |=> !busy) else $error("conversion survived disable");
  chk_channel_held: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
    busy && !done_evt && enable |=> $stable(active_channel))
    else $error("channel changed mid conversion");
  chk_start_taken: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
    start_req |=> busy && tick_cnt == 5'h00) else $error("start not taken");
endmodule
`default_nettype wire

// ### include/adc_ctrl_pkg.sv
// Constants shared by the converter control block and its prescaler
`default_nettype none
package adc_ctrl_pkg;
  // ----------------------------------------------------------------
  // Register indices, byte address is four times the index
  // ----------------------------------------------------------------
  localparam int ADR_W = 8;
  localparam logic [5:0] IDX_RESULT_LOW = 6'h04;
  localparam logic [5:0] IDX_RESULT_HIGH = 6'h05;
  localparam logic [5:0] IDX_CTRL_STATUS = 6'h06;
  localparam logic [5:0] IDX_CHANNEL = 6'h07;
  localparam logic [5:0] IDX_IRQ_STATUS = 6'h08;
  localparam logic [5:0] IDX_IRQ_MASK = 6'h09;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CS_ENABLE = 7;
  localparam int CS_START = 6;
  localparam int CS_FREE_RUN = 5;
  localparam int CS_DONE_FLAG = 4;
  localparam int CS_IRQ_ENABLE = 3;
  localparam int CS_DIV_LSB = 0;
  localparam int DIV_W = 3;
  localparam int CHAN_W = 3;
  localparam int RESULT_W = 10;
  localparam int EV_DONE = 0;
  localparam int EV_LOST = 1;
  localparam int EV_W = 2;
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [DIV_W-1:0] DIV_RESET = 3'h0;
  localparam logic [CHAN_W-1:0] CHAN_RESET = 3'h0;
  localparam logic [RESULT_W-1:0] RESULT_RESET = 10'h000;
  localparam logic [EV_W-1:0] EV_RESET = 2'h0;
  // ----------------------------------------------------------------
  // Timing counts in converter clocks
  // ----------------------------------------------------------------
  localparam int TICK_W = 5;
  localparam logic [TICK_W-1:0] CLKS_FREE_RUN = 5'h0d;
  localparam logic [TICK_W-1:0] CLKS_SINGLE = 5'h0e;
  localparam logic [TICK_W-1:0] CLKS_INIT = 5'h19;
  localparam int PRESCALE_W = 7;

  typedef enum logic {idle_st, converting_st} conv_state_t;

  // Code to counter mask: 000 and 001 both divide by two
  function automatic logic [PRESCALE_W-1:0] div_mask(input logic [DIV_W-1:0] code);
    logic [PRESCALE_W:0] full;
    full = 8'h01 << ((code == 3'h0) ? 3'h1 : code);
    div_mask = full[PRESCALE_W-1:0] - 7'h01;
  endfunction
endpackage
`default_nettype wire

// ### design/converter_prescaler.sv
// Converter clock enable generator derived from the system clock
`default_nettype none
module converter_prescaler (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic run_i,
  input wire logic [adc_ctrl_pkg::DIV_W-1:0] div_sel_i,
  output logic tick_o
);
  import adc_ctrl_pkg::*;

  logic [PRESCALE_W-1:0] count;

  // ----------------------------------------------------------------
  // Free-running divider, held in reset while the converter is off
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count <= 7'h00;
      tick_o <= 1'b0;
    end else if (ce_i) begin
      // Switch-off clear waits for the enable too, so a frozen block keeps its phase
      if (!run_i) begin
        count <= 7'h00;
        tick_o <= 1'b0;
      end else begin
        count <= count + 7'h01;
        tick_o <= ((count & div_mask(div_sel_i)) == div_mask(div_sel_i));
      end
    end
  end

  chk_tick_spacing: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
    tick_o |=> !tick_o) else $error("converter tick repeated back to back");
  chk_tick_off: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
    !run_i |=> !tick_o) else $error("tick while converter disabled");
endmodule
`default_nettype wire

// ### test/adc_core_model.sv
// Behavioural analog core: sample-and-hold, multiplexer and comparator result
`default_nettype none
module adc_core_model (
  input wire logic clk_i,
  input wire logic [adc_ctrl_pkg::CHAN_W-1:0] channel_i,
  input wire logic converting_i,
  output logic [adc_ctrl_pkg::RESULT_W-1:0] result_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import adc_ctrl_pkg::*;
  // ----------------------------------------------------------------
  // Result follows the selected channel
  // ----------------------------------------------------------------
  initial result_o = 10'h000;
  // Outside a conversion the value churns, so a stale sample cannot pass for a good one
  // Inside one the input stays put: no shared output pin is toggled mid-conversion
  always @(posedge clk_i) begin
    if (converting_i) begin
      result_o <= {channel_i[1:0], 5'h15, channel_i};
    end else begin
      result_o <= ~result_o;
    end
  end
endmodule
`default_nettype wire

// ### test/adc_conversion_control_bench.sv
// Self-checking bench for the converter control block
`default_nettype none
module adc_conversion_control_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import adc_ctrl_pkg::*;
  localparam logic [7:0] a_lo = {IDX_RESULT_LOW, 2'b00};
  localparam logic [7:0] a_hi = {IDX_RESULT_HIGH, 2'b00};
  localparam logic [7:0] a_cs = {IDX_CTRL_STATUS, 2'b00};
  localparam logic [7:0] a_ch = {IDX_CHANNEL, 2'b00};
  localparam logic [7:0] a_st = {IDX_IRQ_STATUS, 2'b00};
  localparam logic [7:0] a_mk = {IDX_IRQ_MASK, 2'b00};
  logic clk_i = 1'b0;
  logic rst_i, ce_i, cyc_i, stb_i, we_i, ack_o;
  logic [ADR_W-1:0] adr_i;
  logic [3:0] sel_i;
  logic [31:0] dat_i, dat_o, rd;
  logic global_irq_enable_i, irq_vector_ack_i, conv_irq_o, irq_o;
  logic [RESULT_W-1:0] core_result_i;
  logic [CHAN_W-1:0] channel_o;
  logic converting_o, converter_on_o, adc_clk_en_o, tick_clr;
  int miscompares, cmp_count, cycles, tick_cnt, n;

  always #4 clk_i = ~clk_i;

  adc_conversion_control dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
    .ack_o(ack_o), .global_irq_enable_i(global_irq_enable_i),
    .irq_vector_ack_i(irq_vector_ack_i), .conv_irq_o(conv_irq_o), .irq_o(irq_o),
    .core_result_i(core_result_i), .channel_o(channel_o), .converting_o(converting_o),
    .converter_on_o(converter_on_o), .adc_clk_en_o(adc_clk_en_o));

  adc_core_model core (.clk_i(clk_i), .channel_i(channel_o), .converting_i(converting_o),
    .result_o(core_result_i));
  // ----------------------------------------------------------------
  // Converter clocks counted inside conversions
  // ----------------------------------------------------------------
  always @(posedge clk_i) begin
    if (tick_clr) begin
      tick_cnt <= 0;
    end else if (converting_o === 1'b1 && adc_clk_en_o === 1'b1) begin
      tick_cnt <= tick_cnt + 1;
    end
  end
  // Every polling wait below relies on this ceiling rather than its own bound
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 30000) begin
      miscompares++;
      results();
    end
  end
  // ----------------------------------------------------------------
  // Bus and helper tasks
  // ----------------------------------------------------------------
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= {24'h00_0000, d};
    @(posedge clk_i);
    while (ack_o !== 1'b1) @(posedge clk_i);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    wb(1'b1, a, d);
  endtask
  task automatic rc(input string name, input logic [7:0] a, input logic [7:0] exp);
    wb(1'b0, a, 8'h00);
    chk(name, rd, {24'h00_0000, exp});
  endtask
  task automatic wait_tick();
    @(posedge clk_i);
    while (adc_clk_en_o !== 1'b1) @(posedge clk_i);
  endtask
  task automatic wait_irq();
    @(posedge clk_i);
    while (conv_irq_o !== 1'b1) @(posedge clk_i);
  endtask
  // Vector acknowledge also restarts the tick count for the next conversion
  task automatic vec_ack();
    @(posedge clk_i);
    irq_vector_ack_i <= 1'b1;
    tick_clr <= 1'b1;
    @(posedge clk_i);
    irq_vector_ack_i <= 1'b0;
    tick_clr <= 1'b0;
  endtask
  task automatic results();
    $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    rst_i = 1'b1; ce_i = 1'b1; cyc_i = 1'b0; stb_i = 1'b0; we_i = 1'b0;
    adr_i = 8'h00; sel_i = 4'h1; dat_i = 32'h0000_0000; tick_clr = 1'b0;
    global_irq_enable_i = 1'b1; irq_vector_ack_i = 1'b0;
    miscompares = 0; cmp_count = 0; cycles = 0; tick_cnt = 0;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    rc("cs reset", a_cs, 8'h00);
    rc("chan reset", a_ch, 8'h00);
    rc("mask reset", a_mk, 8'h00);
    wr(8'h40, 8'hff);
    rc("unmapped", 8'h40, 8'h00);
    // A write with byte lane 0 off must leave the register alone
    @(posedge clk_i);
    sel_i <= 4'h0;
    wr(a_ch, 8'h03);
    rc("lane off", a_ch, 8'h00);
    @(posedge clk_i);
    sel_i <= 4'h1;
    for (int k = 0; k < 8; k++) begin
      wr(a_cs, {5'b10000, 3'(k)});
      wait_tick();
      wait_tick();
      n = 0;
      do begin @(posedge clk_i); n++; end while (adc_clk_en_o !== 1'b1);
      chk("period", n, (k < 2) ? 2 : (1 << k));
    end
    chk("enabled", converter_on_o, 1);
    // Single conversion after enable, channel change mid-flight
    wr(a_ch, 8'h05);
    wr(a_cs, 8'h8b);
    vec_ack();
    wr(a_cs, 8'hcb);
    chk("chan captured", channel_o, 5);
    wr(a_ch, 8'h06);
    chk("chan held", channel_o, 5);
    rc("start busy", a_cs, 8'hcb);
    wait_irq();
    chk("init length", tick_cnt, 25);
    rc("done cs", a_cs, 8'h9b);
    rc("low", a_lo, 8'had);
    rc("high", a_hi, 8'h01);
    rc("ev status", a_st, 8'h01);
    chk("irq masked", irq_o, 0);
    wr(a_mk, 8'h01);
    @(negedge clk_i);
    chk("irq unmasked", irq_o, 1);
    wr(a_st, 8'h01);
    @(negedge clk_i);
    chk("irq cleared", irq_o, 0);
    rc("ev cleared", a_st, 8'h00);
    chk("req all set", conv_irq_o, 1);
    @(posedge clk_i);
    global_irq_enable_i <= 1'b0;
    @(negedge clk_i);
    chk("req global off", conv_irq_o, 0);
    @(posedge clk_i);
    global_irq_enable_i <= 1'b1;
    wr(a_cs, 8'h83);
    @(negedge clk_i);
    chk("req enable off", conv_irq_o, 0);
    rc("flag kept", a_cs, 8'h93);
    wr(a_cs, 8'h9b);
    rc("flag cleared", a_cs, 8'h8b);
    // Second single conversion uses the new channel
    vec_ack();
    wr(a_cs, 8'hcb);
    chk("chan next", channel_o, 6);
    wait_irq();
    chk("single length", tick_cnt, 14);
    rc("low 6", a_lo, 8'hae);
    rc("high 6", a_hi, 8'h02);
    vec_ack();
    @(negedge clk_i);
    chk("vector clears", conv_irq_o, 0);
    // Abort by disable, then free run restart needs the init pass again
    wr(a_cs, 8'hcb);
    repeat (30) @(posedge clk_i);
    // Clock enable low freezes the conversion well past its normal end
    ce_i <= 1'b0;
    repeat (200) @(posedge clk_i);
    chk("frozen busy", converting_o, 1);
    chk("frozen no finish", conv_irq_o, 0);
    ce_i <= 1'b1;
    wr(a_cs, 8'h0b);
    @(negedge clk_i);
    chk("aborted", converting_o, 0);
    chk("off", converter_on_o, 0);
    repeat (300) @(posedge clk_i);
    chk("no finish", conv_irq_o, 0);
    wr(a_cs, 8'h8b);
    vec_ack();
    wr(a_cs, 8'heb);
    wait_irq();
    chk("reinit length", tick_cnt, 25);
    vec_ack();
    wait_irq();
    chk("free length", tick_cnt, 13);
    chk("restarted", converting_o, 1);
    // Low read locks the pair across two completions
    rc("lock low", a_lo, 8'hae);
    wr(a_ch, 8'h01);
    chk("chan old", channel_o, 6);
    vec_ack();
    wait_irq();
    vec_ack();
    wait_irq();
    rc("lock high", a_hi, 8'h02);
    rc("lost event", a_st, 8'h03);
    vec_ack();
    wait_irq();
    rc("free low", a_lo, 8'ha9);
    rc("free high", a_hi, 8'h01);
    // Leaving free run lets the running conversion end with no restart
    vec_ack();
    wait_irq();
    wr(a_cs, 8'h8b);
    vec_ack();
    wait_irq();
    repeat (300) @(posedge clk_i);
    chk("stopped", converting_o, 0);
    rc("idle cs", a_cs, 8'h9b);
    results();
  end
endmodule
`default_nettype wire
